// ### lmsd_core.sv
module lmsd_core #(
    parameter int SCAN_CYC = lmsd_pkg::SCAN_CYC,
    parameter int NOL_CYC = lmsd_pkg::NOL_CYC,
    parameter int CDLY_CYC = lmsd_pkg::CDLY_CYC,
    parameter int PWM_DIV = lmsd_pkg::PWM_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Register port from the serial slave
    input wire lmsd_pkg::lmsd_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Matrix drive
    output logic [lmsd_pkg::ROWS-1:0] o_row_switch_n,
    output logic [lmsd_pkg::COLS-1:0] o_column_sink,
    output logic [lmsd_pkg::COLS-1:0][7:0] o_col_current,
    // Fault sensing
    input wire logic [lmsd_pkg::COLS-1:0] i_col_open,
    input wire logic [lmsd_pkg::COLS-1:0] i_col_short,
    output logic [1:0] o_detect_mode,
    // Pad settings
    output logic o_soft_shutdown_n,
    output logic o_logic_threshold_select,
    output logic [2:0] o_row_pulldown_select,
    output logic [2:0] o_column_pullup_select
);
    import lmsd_pkg::*;

    localparam int CW = $clog2(SCAN_CYC + NOL_CYC + CDLY_CYC + 1);
    localparam int DW = $clog2(PWM_DIV + 1);
    localparam logic [7:0] PULL_MASK = 8'h77;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    lmsd_cfg_t cfg_r;
    lmsd_cfg_t wcfg;
    logic [7:0] gcl_r;
    logic [7:0] pull_r;
    logic [7:0] page_r;
    logic [7:0] lock_r;
    logic [7:0] bright_r [DOTS];
    logic [7:0] scale_r [DOTS];
    logic [COLS-1:0] res_r [ROWS];

    wire on_func = page_r == PAGE_FUNC;
    wire on_bright = page_r == PAGE_BRIGHT;
    wire on_scale = page_r == PAGE_SCALE;
    wire dot_ok = i_req.addr <= ADDR_DOT_LAST;
    wire wr_func = i_req.wr && on_func;
    wire srst = wr_func && i_req.addr == ADDR_SRST && i_req.wdata == SRST_KEY;
    wire page_wr = i_req.wr && i_req.addr == ADDR_PAGE && lock_r == LOCK_KEY;
    wire page_ok = i_req.wdata == PAGE_BRIGHT || i_req.wdata == PAGE_SCALE || i_req.wdata == PAGE_FUNC;
    wire cfg_wr = wr_func && i_req.addr == ADDR_CFG;
    wire new_fd = wcfg.fdet == FD_OPEN || wcfg.fdet == FD_SHORT;
    wire trig = cfg_wr && cfg_r.fdet == FD_OFF && new_fd;
    assign wcfg = lmsd_cfg_t'(i_req.wdata);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_r <= lmsd_cfg_t'(REG_RST);
            gcl_r <= REG_RST;
            pull_r <= PULL_RST;
            page_r <= PAGE_BRIGHT;
            lock_r <= LOCK_SHUT;
            for (int i = 0; i < DOTS; i++) begin
                bright_r[i] <= REG_RST;
                scale_r[i] <= REG_RST;
            end
        end else if (srst) begin
            cfg_r <= lmsd_cfg_t'(REG_RST);
            gcl_r <= REG_RST;
            pull_r <= PULL_RST;
            page_r <= PAGE_BRIGHT;
            lock_r <= LOCK_SHUT;
            for (int i = 0; i < DOTS; i++) begin
                bright_r[i] <= REG_RST;
                scale_r[i] <= REG_RST;
            end
        end else if (i_req.wr) begin
            if (i_req.addr == ADDR_LOCK) begin
                lock_r <= i_req.wdata;
            end else if (page_wr) begin
                lock_r <= LOCK_SHUT;
                if (page_ok) begin
                    page_r <= i_req.wdata;
                end
            end else if (on_bright && dot_ok) begin
                bright_r[i_req.addr] <= i_req.wdata;
            end else if (on_scale && dot_ok) begin
                scale_r[i_req.addr] <= i_req.wdata;
            end else if (cfg_wr) begin
                cfg_r <= wcfg;
            end else if (wr_func && i_req.addr == ADDR_GCL) begin
                gcl_r <= i_req.wdata;
            end else if (wr_func && i_req.addr == ADDR_PULL) begin
                pull_r <= i_req.wdata & PULL_MASK;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [7:0] res_off = i_req.addr - ADDR_RES_LO;
    wire [7:0] res_row = res_off / RES_STRIDE;
    wire [7:0] res_byte = res_off % RES_STRIDE;
    wire res_in = i_req.addr >= ADDR_RES_LO && i_req.addr <= ADDR_RES_HI;
    wire res_ok = res_in && res_byte < 8'(RES_BYTES);
    wire [31:0] res_word = res_ok ? 32'(res_r[res_row[2:0]]) : 32'h0000_0000;
    wire [7:0] res_val = res_ok ? res_word[res_byte[1:0]*8 +: 8] : REG_RST;
    wire [7:0] func_val = i_req.addr == ADDR_CFG ? 8'(cfg_r)
                        : i_req.addr == ADDR_GCL ? gcl_r
                        : i_req.addr == ADDR_PULL ? pull_r
                        : res_val;
    wire [7:0] rd_val = i_req.addr == ADDR_LOCK ? lock_r
                      : i_req.addr == ADDR_PAGE ? REG_RST
                      : (on_bright && dot_ok) ? bright_r[i_req.addr]
                      : (on_scale && dot_ok) ? scale_r[i_req.addr]
                      : on_func ? func_val
                      : REG_RST;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= REG_RST;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= rd_val;
            end
        end
    end

    // ----------------------------------------
    // Scan sequencer
    // ----------------------------------------
    lmsd_phase_t phase_r;
    logic [CW-1:0] ph_cnt_r;
    logic [3:0] slot_r;
    logic [3:0] nslots_r;
    logic [2:0] nrows_r;
    logic stop_r;

    wire [3:0] slots_dec = (cfg_r.scan <= SCAN_LAST) ? 4'(MAX_SLOTS) - cfg_r.scan : 4'(MAX_SLOTS);
    wire [2:0] rows_dec = (slots_dec > 4'(ROWS)) ? 3'(ROWS) : slots_dec[2:0];
    wire [CW-1:0] ph_lim = phase_r == PH_SCAN ? CW'(SCAN_CYC - 1)
                         : phase_r == PH_NOL ? CW'(NOL_CYC - 1)
                         : CW'(CDLY_CYC - 1);
    wire ph_done = ph_cnt_r == ph_lim;
    wire slot_end = ph_done && phase_r == PH_CDLY;
    wire last_slot = slot_r == nslots_r - 4'h1;
    wire frame_end = slot_end && last_slot;
    wire [3:0] nxt_slot = last_slot ? 4'h0 : slot_r + 4'h1;
    wire row_act = !stop_r && slot_r < {1'b0, nrows_r};

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_r <= PH_SCAN;
            ph_cnt_r <= '0;
            slot_r <= 4'h0;
            nslots_r <= 4'(MAX_SLOTS);
            nrows_r <= 3'(ROWS);
            stop_r <= 1'b0;
        end else begin
            ph_cnt_r <= ph_done ? '0 : ph_cnt_r + CW'(1);
            if (ph_done) begin
                unique case (phase_r)
                    PH_SCAN: phase_r <= PH_NOL;
                    PH_NOL: phase_r <= PH_CDLY;
                    PH_CDLY: phase_r <= PH_SCAN;
                    default: phase_r <= PH_SCAN;
                endcase
            end
            if (slot_end) begin
                slot_r <= nxt_slot;
            end
            if (frame_end) begin
                nslots_r <= slots_dec;
                nrows_r <= rows_dec;
                stop_r <= cfg_r.scan == SCAN_STOP;
            end
        end
    end

    // ----------------------------------------
    // Per-slot column data
    // ----------------------------------------
    // Latched in the column delay so a slot never sees a torn row
    logic [COLS-1:0][7:0] lat_bri_r;
    logic [COLS-1:0][7:0] lat_cur_r;
    logic [COLS-1:0][7:0] bri_nxt;
    logic [COLS-1:0][7:0] cur_nxt;
    wire [3:0] nxt_row = (stop_r || nxt_slot >= 4'(ROWS)) ? 4'h0 : nxt_slot;
    // Widen before the product: the column count does not fit the row index width
    wire [7:0] row_base = 8'(nxt_row) * 8'(COLS);

    always_comb begin
        for (int c = 0; c < COLS; c++) begin
            bri_nxt[c] = bright_r[row_base + 8'(c)];
            cur_nxt[c] = 8'((16'(gcl_r) * 16'(scale_r[row_base + 8'(c)])) >> 8);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lat_bri_r <= '0;
            lat_cur_r <= '0;
        end else if (phase_r == PH_CDLY) begin
            lat_bri_r <= bri_nxt;
            lat_cur_r <= cur_nxt;
        end
    end

    // ----------------------------------------
    // PWM
    // ----------------------------------------
    logic [DW-1:0] div_r;
    logic [7:0] pwm_cnt_r;
    logic [COLS-1:0] col_on;

    always_comb begin
        for (int c = 0; c < COLS; c++) begin
            col_on[c] = pwm_cnt_r < lat_bri_r[c];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_r <= '0;
            pwm_cnt_r <= 8'h00;
        end else if (div_r == DW'(PWM_DIV - 1)) begin
            div_r <= '0;
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
        end else begin
            div_r <= div_r + DW'(1);
        end
    end

    // ----------------------------------------
    // Fault detection
    // ----------------------------------------
    logic [COLS-1:0] open_s1;
    logic [COLS-1:0] open_s2;
    logic [COLS-1:0] short_s1;
    logic [COLS-1:0] short_s2;
    logic [1:0] det_pend_r;
    logic [1:0] det_mode_r;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            open_s1 <= '0;
            open_s2 <= '0;
            short_s1 <= '0;
            short_s2 <= '0;
        end else begin
            open_s1 <= i_col_open;
            open_s2 <= open_s1;
            short_s1 <= i_col_short;
            short_s2 <= short_s1;
        end
    end

    // A pending run waits for normal operation and a frame edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            det_pend_r <= FD_OFF;
            det_mode_r <= FD_OFF;
            for (int r = 0; r < ROWS; r++) begin
                res_r[r] <= '0;
            end
        end else if (srst) begin
            det_pend_r <= FD_OFF;
            det_mode_r <= FD_OFF;
            for (int r = 0; r < ROWS; r++) begin
                res_r[r] <= '0;
            end
        end else begin
            if (frame_end) begin
                det_mode_r <= cfg_r.run ? det_pend_r : FD_OFF;
                if (cfg_r.run && det_pend_r != FD_OFF) begin
                    for (int r = 0; r < ROWS; r++) begin
                        res_r[r] <= '0;
                    end
                end
            end else if (det_mode_r != FD_OFF && phase_r == PH_SCAN && ph_done && row_act) begin
                res_r[slot_r[2:0]] <= det_mode_r == FD_OPEN ? open_s2 : short_s2;
            end
            if (trig) begin
                det_pend_r <= wcfg.fdet;
            end else if (frame_end && cfg_r.run) begin
                det_pend_r <= FD_OFF;
            end
        end
    end
    assign o_detect_mode = det_mode_r;

    // ----------------------------------------
    // Matrix outputs
    // ----------------------------------------
    wire scan_on = phase_r == PH_SCAN && cfg_r.run;
    wire [ROWS-1:0] row_sel = ROWS'(1) << slot_r[2:0];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_row_switch_n <= '1;
            o_column_sink <= '0;
            o_col_current <= '0;
        end else begin
            o_row_switch_n <= (scan_on && row_act) ? ~row_sel : '1;
            if (!scan_on) begin
                o_column_sink <= '0;
            end else if (det_mode_r != FD_OFF) begin
                o_column_sink <= '1;
            end else begin
                o_column_sink <= col_on;
            end
            o_col_current <= cfg_r.run ? lat_cur_r : '0;
        end
    end

    assign o_soft_shutdown_n = cfg_r.run;
    assign o_logic_threshold_select = cfg_r.thr;
    assign o_row_pulldown_select = pull_r[PD_LSB +: 3];
    assign o_column_pullup_select = pull_r[PU_LSB +: 3];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    page_lock_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        page_wr && !srst |=> lock_r == LOCK_SHUT)
        else $error("lock not cleared after page write");

    page_locked_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_req.wr && i_req.addr == ADDR_PAGE && lock_r != LOCK_KEY && !srst |=> $stable(page_r))
        else $error("page changed while locked");

    soft_reset_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        srst |=> cfg_r == lmsd_cfg_t'(REG_RST) && gcl_r == REG_RST && pull_r == PULL_RST)
        else $error("soft reset left a register set");

    shutdown_blank_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !cfg_r.run |=> o_column_sink == '0 && &o_row_switch_n)
        else $error("matrix lit in shutdown");

    row_onehot_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $onehot0(~o_row_switch_n))
        else $error("two rows on at once");

    scan_len_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(phase_r == PH_NOL) |-> $past(ph_cnt_r) == CW'(SCAN_CYC - 1))
        else $error("scan slot length wrong");

    nol_blank_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        phase_r == PH_NOL ##1 phase_r == PH_NOL |-> &o_row_switch_n && o_column_sink == '0)
        else $error("drive during non-overlap");

    det_trigger_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        trig && !srst |=> det_pend_r == $past(wcfg.fdet))
        else $error("detection trigger lost");

    det_once_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !trig && !frame_end && !srst |=> $stable(det_pend_r))
        else $error("detection armed without trigger");

    stop_rows_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        stop_r |=> &o_row_switch_n)
        else $error("row driven while scan stopped");
endmodule

// ### lmsd_pkg.sv
package lmsd_pkg;
    localparam int COLS = 30;
    localparam int ROWS = 6;
    localparam int DOTS = 180;
    localparam int MAX_SLOTS = 9;
    localparam int RES_BYTES = 4;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_PAGE = 8'hFD;
    localparam logic [7:0] ADDR_LOCK = 8'hFE;
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_GCL = 8'h01;
    localparam logic [7:0] ADDR_PULL = 8'h02;
    localparam logic [7:0] ADDR_RES_LO = 8'h03;
    localparam logic [7:0] ADDR_RES_HI = 8'h1F;
    localparam logic [7:0] ADDR_SRST = 8'h3F;
    localparam logic [7:0] ADDR_DOT_LAST = 8'hB3;
    localparam logic [7:0] RES_STRIDE = 8'h05;
    localparam logic [7:0] PAGE_BRIGHT = 8'h00;
    localparam logic [7:0] PAGE_SCALE = 8'h02;
    localparam logic [7:0] PAGE_FUNC = 8'h04;
    localparam logic [7:0] LOCK_KEY = 8'hC5;
    localparam logic [7:0] LOCK_SHUT = 8'h00;
    localparam logic [7:0] SRST_KEY = 8'hAE;
    localparam logic [7:0] PULL_RST = 8'h55;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int PD_LSB = 4;
    localparam int PU_LSB = 0;
    localparam logic [1:0] FD_OFF = 2'h0;
    localparam logic [1:0] FD_OPEN = 2'h1;
    localparam logic [1:0] FD_SHORT = 2'h2;
    localparam logic [3:0] SCAN_LAST = 4'h7;
    localparam logic [3:0] SCAN_STOP = 4'h8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_SCAN_NS = 32000;
    localparam int T_NOL_NS = 2000;
    localparam int T_CDLY_NS = 2000;
    localparam int SCAN_CYC = (T_SCAN_NS * CLK_MHZ + 999) / 1000;
    localparam int NOL_CYC = (T_NOL_NS * CLK_MHZ + 999) / 1000;
    localparam int CDLY_CYC = (T_CDLY_NS * CLK_MHZ + 999) / 1000;
    localparam int PWM_STEPS = 256;
    // Whole PWM period fits inside one scan slot
    localparam int PWM_DIV = SCAN_CYC / PWM_STEPS;

    typedef enum logic [1:0] {
        PH_SCAN = 2'b00,
        PH_NOL = 2'b01,
        PH_CDLY = 2'b10
    } lmsd_phase_t;

    typedef struct packed {
        logic [3:0] scan;
        logic thr;
        logic [1:0] fdet;
        logic run;
    } lmsd_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lmsd_req_t;
endpackage

// ### lmsd_matrix_model.sv
// ----------------------------------------
// Matrix far side: sense lines from rows and columns
// ----------------------------------------
module lmsd_matrix_model (
    // Clock
    input wire logic i_clk,
    // Drive from the core
    input wire logic [lmsd_pkg::ROWS-1:0] i_row_switch_n,
    input wire logic [lmsd_pkg::COLS-1:0] i_column_sink,
    // Faulty columns chosen by the bench
    input wire logic [lmsd_pkg::COLS-1:0] i_open_mask,
    input wire logic [lmsd_pkg::COLS-1:0] i_short_mask,
    // Sense outputs
    output logic [lmsd_pkg::COLS-1:0] o_col_open,
    output logic [lmsd_pkg::COLS-1:0] o_col_short
);
    timeunit 1ns;
    timeprecision 100ps;
    import lmsd_pkg::*;
    logic [COLS-1:0] tog_r = '0;
    wire lit = ~&i_row_switch_n;
    always @(posedge i_clk) begin
        tog_r <= ~tog_r;
    end
    // Sense means nothing while no row conducts, so it flips every cycle
    assign o_col_open = lit ? (i_open_mask & i_column_sink) : tog_r;
    assign o_col_short = lit ? (i_short_mask & i_column_sink) : ~tog_r;
endmodule

// ### lmsd_core_tb.sv
module lmsd_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lmsd_pkg::*;
    // Short slot so a full PWM period fits one scan phase
    localparam int SLOT = 264;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    lmsd_req_t i_req = '0;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic [ROWS-1:0] o_row_switch_n;
    logic [COLS-1:0] o_column_sink;
    logic [COLS-1:0][7:0] o_col_current;
    logic [COLS-1:0] col_open;
    logic [COLS-1:0] col_short;
    logic [COLS-1:0] open_m = '0;
    logic [COLS-1:0] short_m = '0;
    logic [1:0] o_detect_mode;
    logic o_soft_shutdown_n;
    logic o_logic_threshold_select;
    logic [2:0] o_row_pulldown_select;
    logic [2:0] o_column_pullup_select;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] rnd = 8'h5A;

    always #4 i_clk = ~i_clk;

    lmsd_core #(.SCAN_CYC(256), .NOL_CYC(4), .CDLY_CYC(4), .PWM_DIV(1)) dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_row_switch_n(o_row_switch_n), .o_column_sink(o_column_sink), .o_col_current(o_col_current),
        .i_col_open(col_open), .i_col_short(col_short), .o_detect_mode(o_detect_mode),
        .o_soft_shutdown_n(o_soft_shutdown_n), .o_logic_threshold_select(o_logic_threshold_select),
        .o_row_pulldown_select(o_row_pulldown_select), .o_column_pullup_select(o_column_pullup_select));

    lmsd_matrix_model model (
        .i_clk(i_clk), .i_row_switch_n(o_row_switch_n), .i_column_sink(o_column_sink),
        .i_open_mask(open_m), .i_short_mask(short_m), .o_col_open(col_open), .o_col_short(col_short));

    // ----------------------------------------
    // Expectations and helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [7:0] gain(input logic [7:0] g, input logic [7:0] s);
        logic [15:0] p;
        p = 16'(g) * 16'(s);
        return p[15:8];
    endfunction
    function automatic logic [5:0] rows_exp(input int code);
        if (code == 8) return 6'h00;
        if (code < 4 || code > 7) return 6'h3F;
        return 6'((1 << (9 - code)) - 1);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        i_req = '0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        i_req = '0;
        chk(o_rvalid, 1);
        chk(o_rdata, e);
    endtask
    task automatic page(input logic [7:0] p);
        wr(ADDR_LOCK, LOCK_KEY);
        wr(ADDR_PAGE, p);
    endtask
    task automatic res_chk(input logic [COLS-1:0] m);
        for (int r = 0; r < ROWS; r++) begin
            rchk(8'(3 + 5 * r), m[7:0]);
            rchk(8'(4 + 5 * r), m[15:8]);
            rchk(8'(5 + 5 * r), m[23:16]);
            rchk(8'(6 + 5 * r), {2'b00, m[29:24]});
            rchk(8'(7 + 5 * r), 8'h00);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] b;
        logic [7:0] s;
        logic [7:0] g;
        logic [5:0] seen;
        int on;
        int w;
        tick(8);
        i_arst_n = 1'b1;
        chk(o_row_switch_n, 6'h3F);
        chk(o_column_sink, 0);
        chk({o_row_pulldown_select, o_column_pullup_select}, 6'h2D);
        page(PAGE_FUNC);
        rchk(ADDR_LOCK, LOCK_SHUT);
        rchk(ADDR_CFG, REG_RST);
        rchk(ADDR_GCL, REG_RST);
        rchk(ADDR_PULL, PULL_RST);
        rchk(ADDR_RES_LO, REG_RST);
        wr(ADDR_PAGE, PAGE_SCALE);
        rchk(ADDR_PULL, PULL_RST);
        $display("reset test done");
        rnd = lfsr(rnd);
        wr(ADDR_PULL, rnd);
        rchk(ADDR_PULL, rnd & 8'h77);
        chk({o_row_pulldown_select, o_column_pullup_select}, {rnd[6:4], rnd[2:0]});
        rnd = lfsr(rnd);
        g = rnd;
        wr(ADDR_GCL, g);
        rchk(ADDR_GCL, g);
        page(PAGE_BRIGHT);
        rnd = lfsr(rnd);
        b = rnd;
        wr(8'h25, b);
        wr(ADDR_DOT_LAST, 8'hA5);
        wr(8'hB4, 8'h5A);
        rchk(8'hB4, 8'h00);
        rchk(ADDR_PAGE, 8'h00);
        rchk(ADDR_DOT_LAST, 8'hA5);
        rchk(8'h25, b);
        page(PAGE_SCALE);
        rnd = lfsr(rnd);
        s = rnd;
        wr(8'h25, s);
        rchk(8'h25, s);
        rchk(ADDR_DOT_LAST, 8'h00);
        page(PAGE_FUNC);
        wr(ADDR_CFG, 8'h39);
        chk(o_logic_threshold_select, 1);
        chk(o_soft_shutdown_n, 1);
        tick(12 * SLOT);
        w = 0;
        while (o_row_switch_n[1] !== 1'b0 && w < 4000) begin
            tick(1);
            w++;
        end
        chk(o_col_current[7], gain(g, s));
        on = 0;
        while (o_row_switch_n[1] === 1'b0) begin
            on += o_column_sink[7];
            tick(1);
        end
        chk(on, b);
        chk(o_row_switch_n, 6'h3F);
        chk(o_column_sink, 0);
        $display("pwm test done");
        wr(ADDR_CFG, 8'h38);
        tick(1);
        chk(o_row_switch_n, 6'h3F);
        chk(o_column_sink, 0);
        chk(|o_col_current, 0);
        rchk(ADDR_GCL, g);
        $display("shutdown test done");
        open_m = 30'h2AC31F0B ^ {22'h0, rnd};
        short_m = ~open_m;
        wr(ADDR_GCL, 8'h01);
        wr(ADDR_CFG, 8'h31);
        wr(ADDR_CFG, 8'h33);
        w = 0;
        while (o_detect_mode !== FD_OPEN && w < 4000) begin
            tick(1);
            w++;
        end
        chk(o_detect_mode, FD_OPEN);
        tick(14 * SLOT);
        res_chk(open_m);
        wr(ADDR_CFG, 8'h35);
        tick(18 * SLOT);
        chk(o_detect_mode, FD_OFF);
        res_chk(open_m);
        wr(ADDR_CFG, 8'h31);
        wr(ADDR_CFG, 8'h35);
        tick(18 * SLOT);
        res_chk(short_m);
        $display("detection test done");
        for (int k = 0; k <= 9; k++) begin
            wr(ADDR_CFG, {4'(k), 4'h1});
            tick(2500);
            seen = '0;
            repeat (2500) begin
                tick(1);
                seen |= ~o_row_switch_n;
            end
            chk(seen, rows_exp(k));
        end
        $display("scan test done");
        wr(ADDR_SRST, SRST_KEY);
        tick(1);
        chk(o_soft_shutdown_n, 0);
        chk({o_row_pulldown_select, o_column_pullup_select}, 6'h2D);
        page(PAGE_FUNC);
        rchk(ADDR_GCL, 8'h00);
        rchk(ADDR_RES_LO, 8'h00);
        $display("soft reset test done");
        complete_run;
    end

    initial begin
        #(8 * 95000);
        miscompares++;
        complete_run;
    end
endmodule
